// >>> sgpm_defines.vh
// Constants for the shared GPIO pin multiplexer
`ifndef SGPM_DEFINES_VH
`define SGPM_DEFINES_VH
// Host interface mode codes on the mode strap bus
`define SGPM_HOST_8080 3'h0
`define SGPM_HOST_6800 3'h2
`define SGPM_HOST_SERIAL_BIT 2
// Panel bus selection codes
`define SGPM_PANEL_GPIO 2'h3
`define SGPM_PANEL_16 2'h2
`define SGPM_PANEL_24 2'h0
// Reset filter: low time must exceed this many clock cycles
`define SGPM_RST_LOW_CYCLES 6'h20
`define SGPM_RST_CNT_W 6
`endif

// >>> sgpm_pin_mux.v
// Shared GPIO pin multiplexer with reset-pin low-time filter
//
// Behaviour
// - Port A bits 7..0 drive host data bus bits 15..8.
// - Port A owns pins only in 8-bit parallel or serial host mode.
// - Port B input bit 4 samples the I2C master clock pin.
// - Port B output bit 4 drives the open-drain I2C master data pin.
// - Port B bits 3..0 map to cmd/data select, write, read, chip select.
// - Port B configurable only in serial host mode, else host strobes/I2C.
// - Port C bit 7 drives PWM0 pin only while PWM0 disabled; its input always reads 0.
// - Port C 6..0 map to flash data3, data2, sel1, sel0, MISO, MOSI, clock.
// - Port C 6..0 usable only while flash master disabled.
// - Port D 7..0 map to panel data bits 18,2,17,16,9,8,1,0.
// - Port D owns those pins in 16-bit panel width and in all-GPIO panel mode.
// - Reset only after reset input low for more than 32 cycles.
// - Port A and D output modes configurable while port owns pins.
// - Panel code 11b all GPIO, 10b 16-bit colour, 00b 24-bit colour.
`timescale 1ns/10ps
`default_nettype none
`include "sgpm_defines.vh"
module sgpm_pin_mux (
  input wire clk, // Core clock
  input wire nrst, // Raw external reset pin, active low
  output wire core_rst_n, // Filtered internal reset, active low
  input wire [2:0] host_mode, // Host interface mode straps
  input wire host_bus16, // Parallel host uses 16-bit data
  input wire pwm0_enable, // PWM channel 0 enabled
  input wire flash_enable, // Serial flash master enabled
  input wire [1:0] panel_sel, // Panel bus selection code
  // Port A
  input wire [7:0] port_a_out, // Port A output data
  input wire [7:0] port_a_oe, // Port A output enables
  input wire [7:0] port_a_od, // Port A open-drain mode per bit
  output wire [7:0] port_a_in, // Port A input data
  output wire port_a_owned, // Port A owns its pins
  // Host data bus upper byte from host interface
  input wire [7:0] host_data_hi_out, // Host data out bits 15..8
  input wire host_data_hi_oe, // Host data drive enable
  output wire [7:0] host_data_hi_in, // Host data in bits 15..8
  // Host data bus upper byte pins
  input wire [7:0] host_data_bus_i, // Pin level bits 15..8
  output wire [7:0] host_data_bus_o, // Pin drive bits 15..8
  output wire [7:0] host_data_bus_oe, // Pin enable bits 15..8
  // Port B
  input wire [3:0] port_b_out, // Port B bits 3..0 output data
  input wire [3:0] port_b_oe, // Port B bits 3..0 output enables
  output wire [3:0] port_b_in, // Port B bits 3..0 input data
  input wire port_b_out4, // Port B output bit 4
  output wire port_b_in4, // Port B input bit 4
  output wire port_b_owned, // Port B owns its pins
  // Host strobe pins {cmd/data select, write, read, chip select}
  input wire [3:0] host_strobe_pin_i, // Strobe pin levels
  output wire [3:0] host_strobe_pin_o, // Strobe pin drive
  output wire [3:0] host_strobe_pin_oe, // Strobe pin enable
  output wire [3:0] host_strobe_in, // Strobes to host interface
  // I2C master
  input wire i2c_master_clock_pin, // I2C clock pin level
  input wire i2c_sda_drive_low, // I2C master pulls data low
  output wire i2c_master_data_pin_o, // I2C data pin drive value
  output wire i2c_master_data_pin_oe, // I2C data pin enable
  output wire i2c_clock_in, // I2C clock to master
  // Port C
  input wire [7:0] port_c_out, // Port C output data
  input wire [7:0] port_c_oe, // Port C output enables
  input wire [7:0] port_c_od, // Port C open-drain mode per bit
  output wire [7:0] port_c_in, // Port C input data
  output wire [7:0] port_c_owned, // Port C ownership per bit
  input wire pwm0_out, // PWM channel 0 waveform
  output wire pwm0_pin_o, // PWM0 pin drive
  output wire pwm0_pin_oe, // PWM0 pin enable
  // Flash master {data3, data2, sel1_n, sel0_n, miso, mosi, clock}
  input wire [6:0] flash_out, // Flash master outputs
  input wire [6:0] flash_oe, // Flash master enables
  output wire [6:0] flash_in, // Flash pin levels to master
  input wire [6:0] flash_pin_i, // Flash pin levels
  output wire [6:0] flash_pin_o, // Flash pin drive
  output wire [6:0] flash_pin_oe, // Flash pin enable
  // Port D
  input wire [7:0] port_d_out, // Port D output data
  input wire [7:0] port_d_oe, // Port D output enables
  input wire [7:0] port_d_od, // Port D open-drain mode per bit
  output wire [7:0] port_d_in, // Port D input data
  output wire port_d_owned, // Port D owns its pins
  // Panel data bus
  input wire [23:0] panel_rgb, // Panel colour data from display logic
  input wire [23:0] panel_data_bus_i, // Panel pin levels
  output wire [23:0] panel_data_bus_o, // Panel pin drive
  output wire [23:0] panel_data_bus_oe // Panel pin enable
);
  // Reset filter state
  reg [`SGPM_RST_CNT_W-1:0] low_cnt_ff;
  reg [`SGPM_RST_CNT_W-1:0] nxt_low_cnt;
  reg rst_n_ff;
  reg nxt_rst_n;
  wire host_serial;
  wire panel_16;
  wire panel_gpio;
  wire [7:0] pd_idx [0:7];
  wire [23:0] pd_gpio_mask;
  wire [23:0] pd_gpio_o;
  wire [23:0] pd_gpio_oe;

  // Low-time counter: restarts while pin high, saturates at threshold
  always @*
  begin
    nxt_low_cnt = low_cnt_ff;
    nxt_rst_n = rst_n_ff;
    if (nrst)
    begin
      nxt_low_cnt = {`SGPM_RST_CNT_W{1'b0}};
      nxt_rst_n = 1'b1;
    end
    // A count of 32 means this edge is the 33rd low sample, so the low time exceeds 32 cycles
    else if (low_cnt_ff >= `SGPM_RST_LOW_CYCLES)
      nxt_rst_n = 1'b0;
    else
      nxt_low_cnt = low_cnt_ff + 6'h01;
  end

  // Counter registers; internal reset comes only from the filter
  always @(posedge clk)
  begin
    low_cnt_ff <= nxt_low_cnt;
    rst_n_ff <= nxt_rst_n;
  end

  assign core_rst_n = rst_n_ff;

  // Mode decode
  assign host_serial = host_mode[`SGPM_HOST_SERIAL_BIT];
  assign port_a_owned = host_serial | ~host_bus16;
  assign port_b_owned = host_serial;
  assign panel_16 = (panel_sel == `SGPM_PANEL_16);
  assign panel_gpio = (panel_sel == `SGPM_PANEL_GPIO);
  assign port_d_owned = panel_16 | panel_gpio;

  // Port A over host data bits 15..8, push-pull or open-drain
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_port_a
      assign host_data_bus_o[gi] = port_a_owned ? (port_a_od[gi] ? 1'b0 : port_a_out[gi])
                                                : host_data_hi_out[gi];
      assign host_data_bus_oe[gi] = port_a_owned ? (port_a_oe[gi] & ~(port_a_od[gi] & port_a_out[gi]))
                                                 : host_data_hi_oe;
    end
  endgenerate
  assign port_a_in = port_a_owned ? host_data_bus_i : 8'h00;
  assign host_data_hi_in = port_a_owned ? 8'h00 : host_data_bus_i;

  // Port B over host strobes and I2C pins
  assign host_strobe_pin_o = port_b_out;
  assign host_strobe_pin_oe = port_b_owned ? port_b_oe : 4'h0;
  assign port_b_in = port_b_owned ? host_strobe_pin_i : 4'h0;
  assign host_strobe_in = port_b_owned ? 4'hF : host_strobe_pin_i;
  assign port_b_in4 = port_b_owned ? i2c_master_clock_pin : 1'b0;
  assign i2c_clock_in = port_b_owned ? 1'b1 : i2c_master_clock_pin;
  // Data pin is open-drain in both uses: only ever pulled low
  assign i2c_master_data_pin_o = 1'b0;
  assign i2c_master_data_pin_oe = port_b_owned ? ~port_b_out4 : i2c_sda_drive_low;

  // Port C bit 7 over PWM0 pin
  assign pwm0_pin_o = pwm0_enable ? pwm0_out : (port_c_od[7] ? 1'b0 : port_c_out[7]);
  assign pwm0_pin_oe = pwm0_enable ? 1'b1 : (port_c_oe[7] & ~(port_c_od[7] & port_c_out[7]));
  assign port_c_in[7] = 1'b0;
  assign port_c_owned = {~pwm0_enable, {7{~flash_enable}}};

  // Port C bits 6..0 over flash master pins, same bit order
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_port_c
      assign flash_pin_o[gi] = flash_enable ? flash_out[gi]
                                            : (port_c_od[gi] ? 1'b0 : port_c_out[gi]);
      assign flash_pin_oe[gi] = flash_enable ? flash_oe[gi]
                                             : (port_c_oe[gi] & ~(port_c_od[gi] & port_c_out[gi]));
      assign port_c_in[gi] = flash_enable ? 1'b0 : flash_pin_i[gi];
      assign flash_in[gi] = flash_enable ? flash_pin_i[gi] : 1'b0;
    end
  endgenerate

  // Panel pin index for each port D bit
  assign pd_idx[7] = 8'h12;
  assign pd_idx[6] = 8'h02;
  assign pd_idx[5] = 8'h11;
  assign pd_idx[4] = 8'h10;
  assign pd_idx[3] = 8'h09;
  assign pd_idx[2] = 8'h08;
  assign pd_idx[1] = 8'h01;
  assign pd_idx[0] = 8'h00;

  // Scatter port D onto its panel pins
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_pd
      wire [7:0] hit;
      wire [7:0] hit_o;
      wire [7:0] hit_oe;
      genvar gj;
      for (gj = 0; gj < 8; gj = gj + 1)
      begin : g_bit
        assign hit[gj] = (pd_idx[gj] == gi);
        assign hit_o[gj] = hit[gj] & ~port_d_od[gj] & port_d_out[gj];
        assign hit_oe[gj] = hit[gj] & port_d_oe[gj] & ~(port_d_od[gj] & port_d_out[gj]);
      end
      assign pd_gpio_mask[gi] = |hit;
      assign pd_gpio_o[gi] = |hit_o;
      assign pd_gpio_oe[gi] = |hit_oe;
    end
  endgenerate

  // Panel pins: 24-bit colour, 16-bit 5:6:5 packed high, or GPIO
  wire [23:0] rgb565;
  assign rgb565 = {panel_rgb[15:11], 3'h0, panel_rgb[10:5], 2'h0, panel_rgb[4:0], 3'h0};
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_panel
      assign panel_data_bus_o[gi] = (port_d_owned & pd_gpio_mask[gi]) ? pd_gpio_o[gi]
                                  : (panel_16 ? rgb565[gi] : (panel_gpio ? 1'b0 : panel_rgb[gi]));
      assign panel_data_bus_oe[gi] = (port_d_owned & pd_gpio_mask[gi]) ? pd_gpio_oe[gi] : ~panel_gpio;
    end
  endgenerate

  // Gather port D inputs
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_din
      assign port_d_in[gi] = port_d_owned ? panel_data_bus_i[pd_idx[gi][4:0]] : 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> sgpm_board.sv
// Board-side model of one group of shared pins
`timescale 1ns/10ps
`default_nettype none
module sgpm_board #(parameter int W = 8) (
  input wire logic clk, // Core clock
  input wire logic [W-1:0] pin_o, // Drive value from the chip
  input wire logic [W-1:0] pin_oe, // Drive enable from the chip
  output wire logic [W-1:0] pin_i // Level seen on the pins
);
  logic [W-1:0] float_ff = '0;
  // Undriven pins follow a Johnson count: one pin flips per cycle, each holds its level W cycles
  always @(posedge clk)
  begin
    float_ff <= {float_ff[W-2:0], ~float_ff[W-1]};
  end
  // Driven pins show what the chip drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & float_ff);
endmodule
`default_nettype wire

// >>> sgpm_checker.sv
// Assertions watching the shared GPIO pin multiplexer ports
`timescale 1ns/10ps
`default_nettype none
module sgpm_checker (
  input wire logic clk, nrst, core_rst_n, host_bus16, pwm0_enable, pwm0_out, pwm0_pin_o, flash_enable, // Controls
  input wire logic port_a_owned, port_b_owned, port_d_owned, port_b_in4, i2c_master_clock_pin, // Owners, port B input bit 4, I2C clock pin
  input wire logic [1:0] panel_sel, // Panel code
  input wire logic [2:0] host_mode, // Host straps
  input wire logic [3:0] host_strobe_in, host_strobe_pin_i, port_b_in, // Strobes
  input wire logic [6:0] flash_pin_o, // Flash pins
  input wire logic [7:0] port_a_out, port_a_oe, port_a_od, host_data_bus_o, host_data_bus_oe, // Port A
  input wire logic [7:0] port_c_out, port_c_od, port_d_out, port_d_od, // Ports C and D
  input wire logic [23:0] panel_data_bus_o // Panel pins
);
  logic [5:0] low_cnt_ff = 6'h00;
  // Counts consecutive low samples of the raw reset pin, saturating
  always_ff @(posedge clk)
  begin
    low_cnt_ff <= nrst ? 6'h00 : low_cnt_ff + {5'h00, ~&low_cnt_ff};
  end
  default clocking @(posedge clk); endclocking
  sequence s_pin_release; !nrst ##1 nrst; endsequence
  sequence s_filter_trip; $fell(core_rst_n); endsequence
  a_port_a_route:
    assert property (port_a_owned && port_a_od == 8'h00 |-> {host_data_bus_o, host_data_bus_oe} == {port_a_out, port_a_oe})
      else $error("port A not on host pins");
  a_port_a_owner:
    assert property (port_a_owned == (host_mode[2] || !host_bus16)) else $error("port A owner wrong");
  a_port_b_owner:
    assert property (port_b_owned == host_mode[2]) else $error("port B owner wrong");
  a_port_b_inputs:
    assert property (port_b_owned |-> host_strobe_in == 4'hF && port_b_in == host_strobe_pin_i
      && port_b_in4 == i2c_master_clock_pin) else $error("port B inputs wrong");
  a_pwm_share:
    assert property (pwm0_pin_o == (pwm0_enable ? pwm0_out : port_c_out[7] & ~port_c_od[7])) else $error("pwm pin wrong");
  a_flash_share:
    assert property (!flash_enable |-> flash_pin_o == (port_c_out[6:0] & ~port_c_od[6:0])) else $error("flash pins wrong");
  a_port_d_route:
    assert property (port_d_owned |-> {panel_data_bus_o[18], panel_data_bus_o[2], panel_data_bus_o[17],
      panel_data_bus_o[16], panel_data_bus_o[9], panel_data_bus_o[8], panel_data_bus_o[1],
      panel_data_bus_o[0]} == (port_d_out & ~port_d_od)) else $error("port D not on panel pins");
  a_port_d_owner:
    assert property (!panel_sel[0] |-> port_d_owned == panel_sel[1]) else $error("port D owner wrong");
  a_filter_trip:
    assert property (s_filter_trip |-> low_cnt_ff == 6'h21) else $error("reset trip at wrong count");
  a_filter_release:
    assert property (s_pin_release |=> core_rst_n) else $error("reset not released");
endmodule
bind sgpm_pin_mux sgpm_checker i_sgpm_checker (.*);
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the shared GPIO pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, nrst = 0, host_bus16, pwm0_enable, flash_enable, host_data_hi_oe, port_b_out4, pwm0_out;
  logic i2c_master_clock_pin, i2c_sda_drive_low;
  logic [1:0] panel_sel;
  logic [2:0] host_mode;
  logic [3:0] port_b_out, port_b_oe;
  logic [6:0] flash_out, flash_oe;
  logic [7:0] port_a_out, port_a_oe, port_a_od, host_data_hi_out, port_c_out, port_c_oe, port_c_od;
  logic [7:0] port_d_out, port_d_oe, port_d_od;
  logic [23:0] panel_rgb;
  wire core_rst_n, port_a_owned, port_b_in4, port_b_owned, i2c_master_data_pin_o, i2c_master_data_pin_oe;
  wire i2c_clock_in, pwm0_pin_o, pwm0_pin_oe, port_d_owned;
  wire [3:0] port_b_in, host_strobe_pin_i, host_strobe_pin_o, host_strobe_pin_oe, host_strobe_in;
  wire [6:0] flash_in, flash_pin_i, flash_pin_o, flash_pin_oe;
  wire [7:0] port_a_in, host_data_hi_in, host_data_bus_i, host_data_bus_o, host_data_bus_oe, port_c_in, port_c_owned;
  wire [7:0] port_d_in;
  wire [23:0] panel_data_bus_i, panel_data_bus_o, panel_data_bus_oe;
  typedef struct {int sel; logic [15:0] exp;} sgpm_note_t;
  sgpm_note_t notes[$];
  sgpm_note_t n;
  int seed = 32'h4c78;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  sgpm_pin_mux i_sgpm_pin_mux (.*);
  sgpm_board #(.W(8)) i_board_host (.clk(clk), .pin_o(host_data_bus_o), .pin_oe(host_data_bus_oe), .pin_i(host_data_bus_i));
  sgpm_board #(.W(4)) i_board_strb (.clk(clk), .pin_o(host_strobe_pin_o), .pin_oe(host_strobe_pin_oe), .pin_i(host_strobe_pin_i));
  sgpm_board #(.W(7)) i_board_flash (.clk(clk), .pin_o(flash_pin_o), .pin_oe(flash_pin_oe), .pin_i(flash_pin_i));
  sgpm_board #(.W(24)) i_board_panel (.clk(clk), .pin_o(panel_data_bus_o), .pin_oe(panel_data_bus_oe), .pin_i(panel_data_bus_i));
  always #5 clk = ~clk;
  // Pin drive and enable of a port that may own its pins, open-drain aware
  function automatic logic [15:0] pin_pair(input logic own, input logic [7:0] o, oe, od, ho, hoe);
    return own ? {o & ~od, oe & ~(od & o)} : {ho, hoe};
  endfunction
  // Output view selected by a note
  function automatic logic [15:0] seen(input int sel);
    case (sel)
      0: return {host_data_bus_o, host_data_bus_oe};
      1: return {port_a_in, port_d_in};
      2: return {panel_data_bus_o[18], panel_data_bus_o[2], panel_data_bus_o[17], panel_data_bus_o[16],
        panel_data_bus_o[9], panel_data_bus_o[8], panel_data_bus_o[1], panel_data_bus_o[0], 8'h00};
      3: return {12'h000, pwm0_pin_o, i2c_clock_in, i2c_master_data_pin_oe, port_b_owned};
      default: return {15'h0000, core_rst_n};
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(input int sel, input logic [15:0] exp);
    notes.push_back('{sel, exp});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Fresh random values on every input except clk, nrst and the pin levels from the boards
  task automatic shuffle;
    {host_mode, host_bus16, pwm0_enable, flash_enable, port_a_out, port_a_oe, port_a_od} <= 30'($random(seed));
    {host_data_hi_out, host_data_hi_oe, port_b_out, port_b_oe, port_b_out4, i2c_master_clock_pin, i2c_sda_drive_low,
      pwm0_out} <= 21'($random(seed));
    {port_c_out, port_c_oe, port_c_od} <= 24'($random(seed));
    {port_d_out, port_d_oe, port_d_od} <= 24'($random(seed));
    panel_rgb <= 24'($random(seed));
    {flash_out, flash_oe, panel_sel} <= 16'($random(seed));
  endtask
  // Reset pin low for len cycles, then released
  task automatic hold_low(input int len);
    for (int i = 0; i < len + 3; i++)
    begin
      @(posedge clk);
      nrst <= (i >= len);
      #1;
      note(4, {15'h0000, !(i >= 33 && i <= len)});
    end
  endtask
  // Compare pending notes once outputs have settled
  always @(negedge clk)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      check($sformatf("view%0d", n.sel), seen(n.sel), n.exp);
    end
  // Cuts a hung run short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    shuffle();
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (300)
    begin
      @(posedge clk);
      shuffle();
      #1;
      note(0, pin_pair(host_mode[2] | ~host_bus16, port_a_out, port_a_oe, port_a_od, host_data_hi_out,
        {8{host_data_hi_oe}}));
      note(1, {(host_mode[2] | ~host_bus16) ? host_data_bus_i : 8'h00, panel_sel[1] ? {panel_data_bus_i[18],
        panel_data_bus_i[2], panel_data_bus_i[17], panel_data_bus_i[16], panel_data_bus_i[9], panel_data_bus_i[8],
        panel_data_bus_i[1], panel_data_bus_i[0]} : 8'h00});
      note(2, pin_pair(panel_sel[1], port_d_out, port_d_oe, port_d_od, {panel_rgb[18], panel_rgb[2], panel_rgb[17],
        panel_rgb[16], panel_rgb[9], panel_rgb[8], panel_rgb[1], panel_rgb[0]}, 8'h00) & 16'hFF00);
      note(3, {12'h000, pwm0_enable ? pwm0_out : port_c_out[7] & ~port_c_od[7], host_mode[2] | i2c_master_clock_pin,
        host_mode[2] ? ~port_b_out4 : i2c_sda_drive_low, host_mode[2]});
    end
    hold_low(32);
    hold_low(33);
    hold_low(40);
    give_verdict();
  end
endmodule
`default_nettype wire
